// ---- common/ess_pkg.sv ----
// Shared constants and types for the encoder slave synchronisation block
package ess_pkg;

  typedef enum logic [2:0] {
    ESS_LINE_FIELD = 3'h0,
    ESS_LINE_VSYNC = 3'h1,
    ESS_FIELD_ONLY = 3'h2,
    ESS_VSYNC_ONLY = 3'h3,
    ESS_EAV_FRAME  = 3'h4
  } ess_mode_e;

  typedef enum logic [1:0] {
    PRE_IDLE = 2'h0,
    PRE_ONE  = 2'h1,
    PRE_TWO  = 2'h2,
    PRE_XY   = 2'h3
  } ess_pre_e;

  // Reset mode: line-locked, field flag plus line sync
  localparam ess_mode_e MODE_RESET = ESS_LINE_FIELD;
  // Nominal NTSC line of 1716 samples and frame of 525 lines
  localparam logic [10:0] LINE_LAST = 11'h6B3;
  localparam logic [9:0] FRAME_LAST = 10'h20C;
  localparam logic [9:0] HALF_LINES = 10'h107;
  localparam logic [9:0] HALF_LAST = 10'h106;
  // Three missed checks: lost when the count already stands at two
  localparam logic [1:0] FAIL_LAST = 2'h2;
  localparam logic [7:0] PREAMBLE_FF = 8'hFF;
  localparam logic [7:0] PREAMBLE_00 = 8'h00;
  localparam int RESET_HOLD_CYCLES = 5;

  function automatic logic active_level(input logic pol, input logic v);
    return pol ? v : ~v;
  endfunction : active_level

endpackage : ess_pkg

// ---- rtl/ess_eav_decoder.sv ----
// Timing reference word finder with protection-bit check
`timescale 1ns/10ps
module ess_eav_decoder
  import ess_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] data,
  output logic word_stb,
  output logic word_err,
  output logic eav_stb,
  output logic eav_f
);

  ess_pre_e pre_r, pre_nxt;
  logic word_stb_r, word_stb_nxt, word_err_r, word_err_nxt;
  logic eav_stb_r, eav_stb_nxt, eav_f_r, eav_f_nxt;
  logic f, v, h, code_ok;

  assign f = data[6];
  assign v = data[5];
  assign h = data[4];
  assign code_ok = data[7] && data[3] == (v ^ h) && data[2] == (f ^ h)
                   && data[1] == (f ^ v) && data[0] == (f ^ v ^ h);

  always_comb begin
    word_stb_nxt = 1'b0;
    word_err_nxt = 1'b0;
    eav_stb_nxt = 1'b0;
    eav_f_nxt = eav_f_r;
    pre_nxt = (data == PREAMBLE_FF) ? PRE_ONE : PRE_IDLE;
    unique case (pre_r)
      PRE_IDLE: ;
      PRE_ONE: if (data == PREAMBLE_00) pre_nxt = PRE_TWO;
      PRE_TWO: if (data == PREAMBLE_00) pre_nxt = PRE_XY;
      PRE_XY: begin
        word_stb_nxt = 1'b1;
        word_err_nxt = ~code_ok;
        // Corrupted words never move the flag
        if (code_ok && h) begin
          eav_stb_nxt = 1'b1;
          eav_f_nxt = f;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pre_r <= PRE_IDLE;
      word_stb_r <= 1'b0;
      word_err_r <= 1'b0;
      eav_stb_r <= 1'b0;
      eav_f_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      word_stb_r <= word_stb_nxt;
      word_err_r <= word_err_nxt;
      eav_stb_r <= eav_stb_nxt;
      eav_f_r <= eav_f_nxt;
    end
  end

  assign word_stb = word_stb_r;
  assign word_err = word_err_r;
  assign eav_stb = eav_stb_r;
  assign eav_f = eav_f_r;

endmodule : ess_eav_decoder

// ---- rtl/ess_slave_sync.sv ----
// Slave-mode timing lock for the video encoder
`timescale 1ns/10ps
// Overview of operation
// - First field flag edge arms the line count clear; the next line sync edge clears it and starts encoding.
// - Every line sync edge in line modes restarts the sample counter.
// - Sample after the delayed sync edge is Cb; source phases data to match.
// - Sync inputs delayed zero to three clocks by the adjust field.
// - Early line sync reinitialises the sample counter and sync signals.
// - Long line: sample counter holds at end value until late line sync.
// - Field flag mode: field count on each transition; line reset after active edge.
// - Vertical sync turned into odd/even waveform; field count per vertical edge.
// - Line and field sync polarities programmable independently.
// - Field-only mode derives line sync, drives it; first edge starts encoding.
// - Frame modes check each frame sync; lock lost after three misses.
// - Lost with free-run: keep timing, resync on next edge anywhere.
// - Lost, no free-run, sync keep: black video, syncs continue.
// - Lost, no free-run, no sync keep: black, no sync tips or digital syncs.
// - Frame modes react to the single programmed edge only.
// - Vertical-only mode uses line sync for parity only; pin not driven.
// - Embedded mode: F flag falling in end words gives frame and line syncs.
// - Embedded mode has same lock checking and fallbacks as field-only mode.
// - Reference words decoded; two successive errors set poor quality status.
// - Reset held five clocks (no hold count here: reset_n acts on each clock it is low); reset selects line-locked field flag mode.
module ess_slave_sync
  import ess_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [2:0] mode_sel,
  input wire logic mode_load,
  input wire logic [1:0] sync_in_adjust,
  input wire logic hsync_pol,
  input wire logic vsync_pol,
  input wire logic free_run_en,
  input wire logic sync_keep,
  input wire logic status_clear,
  input wire logic line_sync_in,
  input wire logic field_parity_pin_in,
  input wire logic [7:0] video_data,
  output logic line_sync_out,
  output logic line_sync_oe_n,
  output logic field_parity_pin_out,
  output logic field_parity_pin_oe_n,
  output logic field_parity_flag,
  output logic [10:0] sample_count,
  output logic [9:0] line_count,
  output logic [2:0] field_count,
  output logic [1:0] cb_phase,
  output logic line_start,
  output logic encode_active,
  output logic force_black,
  output logic sync_tips_en,
  output logic lock_lost,
  output logic poor_quality
);

  ess_mode_e mode_r, mode_nxt;
  logic line_meta_r, line_meta_nxt, line_pin_r, line_pin_nxt;
  logic field_meta_r, field_meta_nxt, field_pin_r, field_pin_nxt;
  logic [7:0] data_meta_r, data_meta_nxt, data_pin_r, data_pin_nxt;
  logic [2:0] line_dly_r, line_dly_nxt, field_dly_r, field_dly_nxt;
  logic line_prev_r, line_prev_nxt, field_prev_r, field_prev_nxt;
  logic [10:0] sample_r, sample_nxt;
  logic [9:0] line_r, line_nxt;
  logic [2:0] field_r, field_nxt;
  logic [1:0] phase_r, phase_nxt, fail_r, fail_nxt;
  logic parity_r, parity_nxt, arm_r, arm_nxt, started_r, started_nxt;
  logic encoding_r, encoding_nxt, lock_r, lock_nxt, lost_r, lost_nxt;
  logic start_r, start_nxt, f_prev_r, f_prev_nxt, err_seen_r, err_seen_nxt;
  logic poor_r, poor_nxt, black_r, black_nxt, tip_r, tip_nxt;
  logic lout_r, lout_nxt, loe_n_r, loe_n_nxt, fout_r, fout_nxt, foe_n_r, foe_n_nxt;
  logic [3:0] line_tap, field_tap;
  logic line_lvl, field_lvl, line_edge, field_edge, field_any;
  logic line_based, field_evt, field_act, frame_evt, at_end, restart, syncs_on;
  logic word_stb, word_err, eav_stb, eav_f;

  ess_eav_decoder u_eav (
    .clock(clock),
    .reset_n(reset_n),
    .data(data_pin_r),
    .word_stb(word_stb),
    .word_err(word_err),
    .eav_stb(eav_stb),
    .eav_f(eav_f)
  );

  // selectable tap on the synchronised pins
  assign line_tap = {line_dly_r, line_pin_r};
  assign field_tap = {field_dly_r, field_pin_r};
  assign line_lvl = active_level(hsync_pol, line_tap[sync_in_adjust]);
  assign field_lvl = active_level(vsync_pol, field_tap[sync_in_adjust]);
  assign line_edge = line_lvl & ~line_prev_r;
  assign field_edge = field_lvl & ~field_prev_r;
  assign field_any = field_lvl ^ field_prev_r;
  assign line_based = mode_r == ESS_LINE_FIELD || mode_r == ESS_LINE_VSYNC;
  // field count on every flag transition in field flag mode, else on the vertical edge
  assign field_evt = (mode_r == ESS_LINE_FIELD) ? field_any : field_edge;
  assign field_act = (mode_r == ESS_LINE_FIELD) ? field_edge : field_edge & ~parity_r;
  assign at_end = sample_r == LINE_LAST && line_r == FRAME_LAST;
  always_comb begin
    unique case (mode_r)
      ESS_FIELD_ONLY: frame_evt = field_edge;
      // coincident line sync marks the odd-field pulse
      ESS_VSYNC_ONLY: frame_evt = field_edge & line_lvl;
      // falling F flag in a valid end word
      ESS_EAV_FRAME: frame_evt = eav_stb & f_prev_r & ~eav_f;
      default: frame_evt = 1'b0;
    endcase
  end
  // resync wherever the edge lands once lock is gone
  assign restart = ~line_based & frame_evt & (~lock_r | lost_r | at_end);
  assign syncs_on = ~lost_r | free_run_en | sync_keep;

  always_comb begin
    mode_nxt = mode_load ? ess_mode_e'(mode_sel) : mode_r;
    line_meta_nxt = line_sync_in;
    line_pin_nxt = line_meta_r;
    field_meta_nxt = field_parity_pin_in;
    field_pin_nxt = field_meta_r;
    data_meta_nxt = video_data;
    data_pin_nxt = data_meta_r;
    line_dly_nxt = {line_dly_r[1:0], line_pin_r};
    field_dly_nxt = {field_dly_r[1:0], field_pin_r};
    line_prev_nxt = line_lvl;
    field_prev_nxt = field_lvl;
    sample_nxt = sample_r;
    line_nxt = line_r;
    field_nxt = field_r;
    phase_nxt = phase_r + 2'h1;
    parity_nxt = parity_r;
    arm_nxt = arm_r;
    started_nxt = started_r;
    encoding_nxt = encoding_r;
    lock_nxt = lock_r;
    lost_nxt = lost_r;
    fail_nxt = fail_r;
    start_nxt = 1'b0;
    f_prev_nxt = eav_stb ? eav_f : f_prev_r;
    if (mode_load) begin
      // Derived waveform restarts even, so the first vertical edge marks odd
      parity_nxt = 1'b0;
      arm_nxt = 1'b0;
      started_nxt = 1'b0;
      encoding_nxt = 1'b0;
      lock_nxt = 1'b0;
      lost_nxt = 1'b0;
      fail_nxt = 2'h0;
    end else if (line_based) begin
      if (mode_r == ESS_LINE_FIELD) parity_nxt = field_lvl;
      else if (field_edge) parity_nxt = ~parity_r;
      if (field_evt) field_nxt = field_r + 3'h1;
      if (field_act) arm_nxt = 1'b1;
      if (line_edge) begin
        // line sync restarts the line, early or not
        sample_nxt = 11'h000;
        // Cb falls on the first sample
        phase_nxt = 2'h0;
        start_nxt = started_r | arm_r | field_act;
        if (arm_r | field_act) begin
          // first line begins at the line sync edge
          line_nxt = 10'h000;
          arm_nxt = 1'b0;
          started_nxt = 1'b1;
          encoding_nxt = 1'b1;
        end else begin
          line_nxt = line_r + 10'h001;
        end
      // hold at end of line until the late sync
      end else if (started_r && sample_r != LINE_LAST) begin
        sample_nxt = sample_r + 11'h001;
      end
    end else begin
      if (restart) begin
        // first edge starts timing; on-time edge clears misses
        sample_nxt = 11'h000;
        line_nxt = 10'h000;
        phase_nxt = 2'h0;
        field_nxt = field_r + 3'h1;
        lock_nxt = 1'b1;
        lost_nxt = 1'b0;
        fail_nxt = 2'h0;
        start_nxt = 1'b1;
        encoding_nxt = 1'b1;
      end else if (lock_r) begin
        if (sample_r == LINE_LAST) begin
          sample_nxt = 11'h000;
          start_nxt = 1'b1;
          line_nxt = at_end ? 10'h000 : line_r + 10'h001;
          if (at_end || line_r == HALF_LAST) field_nxt = field_r + 3'h1;
        end else begin
          sample_nxt = sample_r + 11'h001;
        end
        // missed check at the predicted instant
        if (at_end) begin
          fail_nxt = (fail_r == FAIL_LAST) ? fail_r : fail_r + 2'h1;
          if (fail_r == FAIL_LAST) lost_nxt = 1'b1;
        end
      end
      parity_nxt = line_nxt < HALF_LINES;
    end
  end

  always_comb begin
    // two errored words in a row; a new error beats the clear
    err_seen_nxt = word_stb ? word_err : err_seen_r;
    poor_nxt = (word_stb & word_err & err_seen_r) | (poor_r & ~status_clear);
    // black when lost without free-run; syncs only with keep
    black_nxt = ~line_based & lost_r & ~free_run_en;
    tip_nxt = encoding_r & syncs_on;
    lout_nxt = active_level(hsync_pol, start_nxt & syncs_on);
    fout_nxt = active_level(vsync_pol, parity_nxt & syncs_on);
    loe_n_nxt = ~(mode_r == ESS_FIELD_ONLY || mode_r == ESS_EAV_FRAME);
    foe_n_nxt = ~(mode_r == ESS_EAV_FRAME);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mode_r <= MODE_RESET;
      {line_meta_r, line_pin_r, field_meta_r, field_pin_r} <= 4'h0;
      data_meta_r <= 8'h00;
      data_pin_r <= 8'h00;
      line_dly_r <= 3'h0;
      field_dly_r <= 3'h0;
      {line_prev_r, field_prev_r, parity_r, arm_r, started_r} <= 5'h00;
      {encoding_r, lock_r, lost_r, start_r, f_prev_r, err_seen_r} <= 6'h00;
      {poor_r, black_r, tip_r, lout_r, fout_r} <= 5'h00;
      {loe_n_r, foe_n_r} <= 2'h3;
      sample_r <= 11'h000;
      line_r <= 10'h000;
      field_r <= 3'h0;
      phase_r <= 2'h0;
      fail_r <= 2'h0;
    end else begin
      mode_r <= mode_nxt;
      {line_meta_r, line_pin_r, field_meta_r, field_pin_r} <=
        {line_meta_nxt, line_pin_nxt, field_meta_nxt, field_pin_nxt};
      data_meta_r <= data_meta_nxt;
      data_pin_r <= data_pin_nxt;
      line_dly_r <= line_dly_nxt;
      field_dly_r <= field_dly_nxt;
      {line_prev_r, field_prev_r, parity_r, arm_r, started_r} <=
        {line_prev_nxt, field_prev_nxt, parity_nxt, arm_nxt, started_nxt};
      {encoding_r, lock_r, lost_r, start_r, f_prev_r, err_seen_r} <=
        {encoding_nxt, lock_nxt, lost_nxt, start_nxt, f_prev_nxt, err_seen_nxt};
      {poor_r, black_r, tip_r, lout_r, fout_r} <=
        {poor_nxt, black_nxt, tip_nxt, lout_nxt, fout_nxt};
      {loe_n_r, foe_n_r} <= {loe_n_nxt, foe_n_nxt};
      sample_r <= sample_nxt;
      line_r <= line_nxt;
      field_r <= field_nxt;
      phase_r <= phase_nxt;
      fail_r <= fail_nxt;
    end
  end

  assign line_sync_out = lout_r;
  assign line_sync_oe_n = loe_n_r;
  assign field_parity_pin_out = fout_r;
  assign field_parity_pin_oe_n = foe_n_r;
  assign field_parity_flag = parity_r;
  assign sample_count = sample_r;
  assign line_count = line_r;
  assign field_count = field_r;
  assign cb_phase = phase_r;
  assign line_start = start_r;
  assign encode_active = encoding_r;
  assign force_black = black_r;
  assign sync_tips_en = tip_r;
  assign lock_lost = lost_r;
  assign poor_quality = poor_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_line_restart;
    line_based && !mode_load && line_edge && (started_r || arm_r) |=> sample_r == 11'h000 && start_r;
  endproperty
  a_line_restart: assert property (p_line_restart) else $error("line sync did not restart line");
  property p_early_line;
    line_based && !mode_load && line_edge && sample_r < LINE_LAST |=> sample_r == 11'h000 ##1 sample_r == 11'h001 || line_edge;
  endproperty
  a_early_line: assert property (p_early_line) else $error("early line sync not honoured");
  property p_long_hold;
    line_based && !mode_load && started_r && !line_edge && sample_r == LINE_LAST |=> sample_r == LINE_LAST;
  endproperty
  a_long_hold: assert property (p_long_hold) else $error("sample counter left end of line");
  property p_first_line;
    line_based && !mode_load && line_edge && (arm_r || field_act) |=> line_r == 10'h000 && encoding_r;
  endproperty
  a_first_line: assert property (p_first_line) else $error("first line not started");
  property p_field_count;
    mode_r == ESS_LINE_FIELD && !mode_load && field_any |=> field_r == $past(field_r) + 3'h1;
  endproperty
  a_field_count: assert property (p_field_count) else $error("field count missed transition");
  property p_vsync_parity;
    mode_r == ESS_LINE_VSYNC && !mode_load && field_edge |=> parity_r != $past(parity_r);
  endproperty
  a_vsync_parity: assert property (p_vsync_parity) else $error("parity did not toggle");
  property p_miss_clear;
    restart && lock_r && !mode_load |=> fail_r == 2'h0 && !lost_r;
  endproperty
  a_miss_clear: assert property (p_miss_clear) else $error("miss count not cleared");
  property p_lose_lock;
    !line_based && !mode_load && lock_r && at_end && !frame_evt && fail_r == FAIL_LAST |=> lost_r;
  endproperty
  a_lose_lock: assert property (p_lose_lock) else $error("lock not dropped after three misses");
  property p_keep_sync;
    lost_r && !free_run_en && sync_keep && encoding_r |=> black_r && tip_r;
  endproperty
  a_keep_sync: assert property (p_keep_sync) else $error("sync keep fallback wrong");
  property p_all_black;
    lost_r && !free_run_en && !sync_keep |=> black_r && !tip_r && lout_r == !$past(hsync_pol);
  endproperty
  a_all_black: assert property (p_all_black) else $error("blanking fallback wrong");
  property p_pin_dir;
    mode_r == ESS_VSYNC_ONLY |=> line_sync_oe_n && field_parity_pin_oe_n;
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("line pin driven in vertical-only mode");
  property p_poor;
    word_stb && word_err && err_seen_r |=> poor_r;
  endproperty
  a_poor: assert property (p_poor) else $error("poor quality not flagged");
  c_lock_lost: cover property (!lost_r ##1 lost_r);
  c_poor: cover property (!poor_r ##1 poor_r);
  c_early: cover property (line_based && started_r && line_edge && sample_r < LINE_LAST);
  c_resync: cover property (lost_r && restart);

endmodule : ess_slave_sync

// ---- test/ess_src_model.sv ----
// Upstream video source model: sync pins and multiplexed byte stream
`timescale 1ns/10ps
module ess_src_model (
  input wire logic clock,
  input wire logic hsync_pol,
  input wire logic vsync_pol,
  output logic line_sync,
  output logic field_pin,
  output logic [7:0] video_data
);
  logic h_on = 1'h0;
  logic f_on = 1'h0;
  logic busy = 1'h0;
  logic [7:0] wb = 8'h00;
  logic [7:0] fill = 8'h40;
  assign line_sync = hsync_pol ? h_on : ~h_on;
  assign field_pin = vsync_pol ? f_on : ~f_on;
  assign video_data = busy ? wb : fill;
  // Filler changes every byte and can never form a preamble
  always @(posedge clock) fill <= {4'h4, fill[3:0] + 4'h1};
  // line edge never after vertical edge
  task automatic drive(input logic h, input logic f);
    h_on <= h;
    f_on <= f;
  endtask : drive
  // Preamble then flag byte; bad flips one protection bit
  task automatic send_word(input logic fl, input logic v, input logic hb, input logic bad);
    logic [7:0] xy;
    xy = {1'h1, fl, v, hb, v ^ hb, fl ^ hb, fl ^ v, fl ^ v ^ hb ^ bad};
    busy <= 1'h1;
    wb <= 8'hFF;
    @(posedge clock);
    wb <= 8'h00;
    @(posedge clock);
    @(posedge clock);
    wb <= xy;
    @(posedge clock);
    busy <= 1'h0;
  endtask : send_word
endmodule : ess_src_model

// ---- test/ess_slave_sync_tb.sv ----
// Self-checking bench for the slave synchronisation block
`timescale 1ns/10ps
module ess_slave_sync_tb
  import ess_pkg::*;
;
  localparam int CYC_MAX = 6000;
  typedef struct packed {
    logic [1:0] adj;
    logic hp;
    logic vp;
    logic [3:0] lat;
  } ess_row_s;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic [2:0] mode_sel = 3'h0;
  logic mode_load = 1'h0;
  logic [1:0] sync_in_adjust = 2'h0;
  logic hsync_pol = 1'h1;
  logic vsync_pol = 1'h1;
  logic free_run_en = 1'h0;
  logic sync_keep = 1'h0;
  logic status_clear = 1'h0;
  logic line_sync_in, field_parity_pin_in;
  logic [7:0] video_data;
  logic line_sync_out, line_sync_oe_n, field_parity_pin_out, field_parity_pin_oe_n;
  logic field_parity_flag, line_start, encode_active, force_black;
  logic sync_tips_en, lock_lost, poor_quality;
  logic [10:0] sample_count;
  logic [9:0] line_count;
  logic [2:0] field_count;
  logic [1:0] cb_phase;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  logic [2:0] fc;
  ess_row_s rows [5];

  ess_src_model i_src (.clock, .hsync_pol, .vsync_pol, .line_sync(line_sync_in),
    .field_pin(field_parity_pin_in), .video_data);

  ess_slave_sync i_dut (.clock, .reset_n, .mode_sel, .mode_load, .sync_in_adjust,
    .hsync_pol, .vsync_pol, .free_run_en, .sync_keep, .status_clear, .line_sync_in,
    .field_parity_pin_in, .video_data, .line_sync_out, .line_sync_oe_n,
    .field_parity_pin_out, .field_parity_pin_oe_n, .field_parity_flag, .sample_count,
    .line_count, .field_count, .cb_phase, .line_start, .encode_active, .force_black,
    .sync_tips_en, .lock_lost, .poor_quality);

  initial begin
    forever #4 clock = ~clock;
  end

  task automatic end_sim();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == CYC_MAX) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, cyc, CYC_MAX);
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick

  // Mode change; settle time lets stale pin edges drain first
  task automatic load(input logic [2:0] m);
    @(posedge clock);
    mode_sel <= m;
    mode_load <= 1'h1;
    @(posedge clock);
    mode_load <= 1'h0;
    tick(8);
  endtask : load

  // Drive pin levels at an edge, count edges until a line start
  task automatic edge_line(input logic h, input logic f);
    @(posedge clock);
    i_src.drive(h, f);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (line_start !== 1'h1 && n < 40);
  endtask : edge_line

  task automatic pins(input logic h, input logic f);
    @(posedge clock);
    i_src.drive(h, f);
  endtask : pins

  initial begin
    rows[0] = '{2'h0, 1'h1, 1'h1, 4'h3};
    rows[1] = '{2'h3, 1'h0, 1'h0, 4'h6};
    rows[2] = '{2'h1, 1'h0, 1'h1, 4'h4};
    rows[3] = '{2'h2, 1'h1, 1'h0, 4'h5};
    rows[4] = '{2'h0, 1'h1, 1'h1, 4'h3};
    @(posedge clock);
    #1;
    chk(line_sync_oe_n, 1'h1);
    chk(field_parity_pin_oe_n, 1'h1);
    chk(encode_active, 1'h0);
    chk(poor_quality, 1'h0);
    @(posedge clock);
    reset_n <= 1'h1;
    // Row 0 runs in the mode left by reset, the rest reload it
    foreach (rows[i]) begin
      @(posedge clock);
      sync_in_adjust <= rows[i].adj;
      hsync_pol <= rows[i].hp;
      vsync_pol <= rows[i].vp;
      i_src.drive(1'h0, 1'h0);
      tick(8);
      if (i > 0) begin
        load(3'h0);
      end
      edge_line(1'h1, 1'h1);
      chk(n, rows[i].lat);
      chk(sample_count, 11'h000);
      chk(line_count, 10'h000);
      chk(cb_phase, 2'h0);
      chk(encode_active, 1'h1);
      chk(field_parity_flag, 1'h1);
      chk(line_sync_out, rows[i].hp);
      pins(1'h0, 1'h1);
      #1;
      chk(sample_count, 11'h001);
      chk(line_sync_out, !rows[i].hp);
    end
    // Early line sync
    tick(100);
    edge_line(1'h1, 1'h1);
    chk(n, 3);
    chk(sample_count, 11'h000);
    chk(line_count, 10'h001);
    pins(1'h0, 1'h1);
    // Overlong line stops at the end value
    tick(1800);
    #1;
    chk(sample_count, LINE_LAST);
    chk(line_start, 1'h0);
    edge_line(1'h1, 1'h1);
    chk(sample_count, 11'h000);
    chk(line_count, 10'h002);
    pins(1'h0, 1'h1);
    tick(4);
    #1;
    fc = field_count;
    pins(1'h0, 1'h0);
    tick(8);
    #1;
    chk(field_count, 3'(fc + 3'h1));
    pins(1'h0, 1'h1);
    tick(8);
    edge_line(1'h1, 1'h1);
    chk(line_count, 10'h000);
    chk(field_count, 3'(fc + 3'h2));
    pins(1'h0, 1'h0);
    // Line plus vertical sync mode
    load(3'h1);
    #1;
    fc = field_count;
    edge_line(1'h1, 1'h1);
    chk(n, 3);
    chk(field_count, 3'(fc + 3'h1));
    pins(1'h0, 1'h0);
    tick(8);
    edge_line(1'h1, 1'h1);
    chk(field_count, 3'(fc + 3'h2));
    // Field-only mode: falling edge must not start it
    pins(1'h0, 1'h1);
    load(3'h2);
    #1;
    chk(line_sync_oe_n, 1'h0);
    pins(1'h0, 1'h0);
    tick(10);
    #1;
    chk(encode_active, 1'h0);
    edge_line(1'h0, 1'h1);
    chk(line_start, 1'h1);
    chk(line_sync_out, 1'h1);
    chk(encode_active, 1'h1);
    load(3'h3);
    #1;
    chk(line_sync_oe_n, 1'h1);
    chk(field_parity_pin_oe_n, 1'h1);
    // Vertical edge with line sync active marks the odd field
    pins(1'h0, 1'h0);
    tick(8);
    edge_line(1'h1, 1'h1);
    chk(encode_active, 1'h1);
    chk(line_sync_oe_n, 1'h1);
    // Embedded words: frame event, then two bad words in a row
    load(3'h4);
    #1;
    chk(field_parity_pin_oe_n, 1'h0);
    chk(line_sync_oe_n, 1'h0);
    chk(encode_active, 1'h0);
    @(posedge clock);
    i_src.send_word(1'h1, 1'h0, 1'h1, 1'h0);
    tick(2);
    i_src.send_word(1'h0, 1'h0, 1'h1, 1'h0);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (encode_active !== 1'h1 && n < 40);
    chk(encode_active, 1'h1);
    @(posedge clock);
    i_src.send_word(1'h0, 1'h0, 1'h1, 1'h1);
    tick(10);
    #1;
    chk(poor_quality, 1'h0);
    chk(sync_tips_en, 1'h1);
    chk(lock_lost, 1'h0);
    chk(force_black, 1'h0);
    chk(field_parity_pin_out, 1'h1);
    @(posedge clock);
    i_src.send_word(1'h0, 1'h0, 1'h0, 1'h1);
    tick(10);
    #1;
    chk(poor_quality, 1'h1);
    @(posedge clock);
    status_clear <= 1'h1;
    @(posedge clock);
    status_clear <= 1'h0;
    tick(2);
    #1;
    chk(poor_quality, 1'h0);
    end_sim();
  end
endmodule : ess_slave_sync_tb
